// >>> ddsc_host.sv
`timescale 1ns/1ps
`default_nettype none
module ddsc_host (
	output logic sclk_out,
	output logic sel_n_out,
	output logic sdo_out
);
	// Idle bus: clock low, select high
	initial begin
		sclk_out = 1'b0;
		sel_n_out = 1'b1;
		sdo_out = 1'b0;
	end
	// One frame in mode 0 with an optional pause mid-word
	task automatic send(input logic [23:0] w, input int n, g, input logic on);
		sel_n_out = ~on;
		#150;
		for (int i = n - 1; i >= 0; i--) begin
			sdo_out = w[i];
			#62.5 sclk_out = 1'b1;
			#62.5 sclk_out = 1'b0;
			if (i == 8) #(g);
		end
		#150 sel_n_out = 1'b1;
		sdo_out = ~sdo_out; // Released line shows no stale bit
	endtask : send
endmodule : ddsc_host
`default_nettype wire

// >>> ddsc_map.svh
`ifndef DDSC_MAP_SVH
`define DDSC_MAP_SVH
`define DDSC_WORD_W     16
`define DDSC_CODE_W     8
`define DDSC_SHUT_B_POS 12
`define DDSC_SHUT_A_POS 11
`define DDSC_LOAD_B_POS 9
`define DDSC_LOAD_A_POS 8
`define DDSC_CODE_MSB   7
`define DDSC_N_CHAN     2
`define DDSC_WORD_RST   16'h0000
`define DDSC_CODE_RST   8'h00
`define DDSC_CODE_OFF   8'h00
`define DDSC_SEL_IDLE   1'b1
`endif

// >>> ddsc_pkg.sv
`default_nettype none
package ddsc_pkg;
	`include "ddsc_map.svh"
	typedef logic [`DDSC_CODE_W-1:0] ddsc_code_t;
	typedef logic [`DDSC_WORD_W-1:0] ddsc_word_t;
endpackage : ddsc_pkg
`default_nettype wire

// >>> ddsc_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "ddsc_map.svh"
module ddsc_top (
	input  wire logic          clk_in,
	input  wire logic          sys_rst_in,
	input  wire logic          ser_clk_in,
	input  wire logic          sel_n_in,
	input  wire logic          ser_data_in,
	output logic               commit_out,
	output ddsc_pkg::ddsc_code_t analog_out_first_out,
	output ddsc_pkg::ddsc_code_t analog_out_second_out,
	output logic               out_en_first_out,
	output logic               out_en_second_out,
	output ddsc_pkg::ddsc_code_t code_first_out,
	output ddsc_pkg::ddsc_code_t code_second_out
);
	import ddsc_pkg::*;

	// Channel count; index 0 is the first channel
	localparam int N_CHAN = `DDSC_N_CHAN;

	// Link domain: select and data are timed to the serial clock,
	// so they are read here without a synchroniser
	ddsc_word_t shift_q;
	ddsc_word_t shift_d;

	// Next word: new bit at the bottom, oldest bit drops out
	assign shift_d = {shift_q[`DDSC_WORD_W-2:0], ser_data_in};

	// Shift only while selected; surplus bits push old ones out
	always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			shift_q <= `DDSC_WORD_RST;
		end else if (!sel_n_in) begin
			shift_q <= shift_d;
		end
	end

	// Link edge seen since reset; keeps link checks off stale history
	logic link_seen_q;
	always_ff @(posedge ser_clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			link_seen_q <= 1'b0;
		end else begin
			link_seen_q <= 1'b1;
		end
	end

	// Select crossing into the system domain
	logic sel_s1_q;
	logic sel_s2_q;
	logic sel_s3_q;
	logic sel_rise;

	// Two-flop synchroniser plus a delay stage; idle level at reset
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			sel_s1_q <= `DDSC_SEL_IDLE;
			sel_s2_q <= `DDSC_SEL_IDLE;
			sel_s3_q <= `DDSC_SEL_IDLE;
		end else begin
			sel_s1_q <= sel_n_in;
			sel_s2_q <= sel_s1_q;
			sel_s3_q <= sel_s2_q;
		end
	end

	// Select rise; the shift word is quiet while select is high
	assign sel_rise = sel_s2_q & ~sel_s3_q;

	// Field decode; every control bit acts on its own
	logic [N_CHAN-1:0] load_sel;
	logic [N_CHAN-1:0] shut_sel;
	ddsc_code_t        data_byte;

	assign load_sel[0] = shift_q[`DDSC_LOAD_A_POS];
	assign load_sel[1] = shift_q[`DDSC_LOAD_B_POS];
	assign shut_sel[0] = shift_q[`DDSC_SHUT_A_POS];
	assign shut_sel[1] = shift_q[`DDSC_SHUT_B_POS];
	assign data_byte   = shift_q[`DDSC_CODE_MSB:0];

	// Per-channel results gathered for the ports
	logic [N_CHAN-1:0][`DDSC_CODE_W-1:0] code_all;
	logic [N_CHAN-1:0][`DDSC_CODE_W-1:0] drive_all;
	logic [N_CHAN-1:0]                   active_all;

	// One register stage per channel, no transfer latch behind it
	for (genvar ch = 0; ch < N_CHAN; ch++) begin : g_chan
		ddsc_code_t code_q;
		ddsc_code_t code_d;
		ddsc_code_t drive_q;
		ddsc_code_t drive_d;
		logic       active_q;
		logic       active_d;
		logic       take;

		// Load bit copies the byte at commit; else code is kept
		assign take     = sel_rise & load_sel[ch];
		assign code_d   = take ? data_byte : code_q;

		// Every commit rewrites the shutdown state
		assign active_d = sel_rise ? ~shut_sel[ch] : active_q;

		// Shut channel shows zero; waking shows the kept code
		assign drive_d  = active_d ? code_d : `DDSC_CODE_OFF;

		// Reset stands in for the missing power-on state
		always_ff @(posedge clk_in or posedge sys_rst_in) begin
			if (sys_rst_in) begin
				code_q   <= `DDSC_CODE_RST;
				drive_q  <= `DDSC_CODE_RST;
				active_q <= 1'b1;
			end else begin
				code_q   <= code_d;
				drive_q  <= drive_d;
				active_q <= active_d;
			end
		end

		// Channel results out of the loop
		assign code_all[ch]   = code_q;
		assign drive_all[ch]  = drive_q;
		assign active_all[ch] = active_q;
	end

	// Commit pulse, one clock after the select rise
	logic commit_q;
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			commit_q <= 1'b0;
		end else begin
			commit_q <= sel_rise;
		end
	end

	// Ports from the per-channel flip-flops and the commit flip-flop; codes stand for ref*code/256
	assign analog_out_first_out  = drive_all[0];
	assign analog_out_second_out = drive_all[1];
	assign out_en_first_out      = active_all[0];
	assign out_en_second_out     = active_all[1];
	assign code_first_out        = code_all[0];
	assign code_second_out       = code_all[1];
	assign commit_out            = commit_q;

	// Link-domain checks, one serial clock edge behind

	// Selected edge takes the data pin into the bottom bit
	a_shift_in_bit : assert property (
		@(posedge ser_clk_in) disable iff (sys_rst_in)
		link_seen_q && !$past(sel_n_in)
		|-> shift_q[0] == $past(ser_data_in)
	) else $error("Serial bit not taken");

	// Earlier bits move one place up, first bit ends on top
	a_shift_order : assert property (
		@(posedge ser_clk_in) disable iff (sys_rst_in)
		link_seen_q && !$past(sel_n_in)
		|-> shift_q[`DDSC_WORD_W-1:1] == $past(shift_q[`DDSC_WORD_W-2:0])
	) else $error("Shift order broken");

	// Deselected edges leave the word alone
	a_desel_ignore : assert property (
		@(posedge ser_clk_in) disable iff (sys_rst_in)
		link_seen_q && $past(sel_n_in)
		|-> $stable(shift_q)
	) else $error("Word moved while deselected");

	// System-domain checks

	// Select rise gives a single pulse
	a_rise_once : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise
		|=> !sel_rise
	) else $error("Select rise repeated");

	// Word is quiet when it is committed
	a_word_quiet : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise
		|-> $stable(shift_q)
	) else $error("Word moving at commit");

	// Commit pulse lasts one cycle
	a_commit_pulse : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise
		|=> commit_out ##1 !commit_out
	) else $error("Commit pulse wrong");

	// Commit pulse only after a select rise
	a_commit_cause : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		commit_out
		|-> $past(sel_rise)
	) else $error("Commit without select rise");

	// No select rise, no commit pulse
	a_commit_quiet : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		!sel_rise
		|=> !commit_out
	) else $error("Stray commit pulse");

	// Codes move only at a commit
	a_hold_no_load : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		!$past(sel_rise)
		|-> $stable(code_first_out) && $stable(code_second_out)
	) else $error("Channel code changed without commit");

	// First load bit copies the data byte
	a_load_first : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise && load_sel[0]
		|=> code_first_out == $past(data_byte)
	) else $error("First channel not loaded");

	// Second load bit copies the data byte
	a_load_second : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise && load_sel[1]
		|=> code_second_out == $past(data_byte)
	) else $error("Second channel not loaded");

	// Clear first load bit keeps the first code
	a_keep_first : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise && !load_sel[0]
		|=> $stable(code_first_out)
	) else $error("First code changed without load");

	// Clear second load bit keeps the second code
	a_keep_second : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise && !load_sel[1]
		|=> $stable(code_second_out)
	) else $error("Second code changed without load");

	// Both loads in one word give both channels one code
	a_load_both_same : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise && load_sel[0] && load_sel[1]
		|=> code_first_out == code_second_out
	) else $error("Channels differ after joint load");

	// First shutdown bit sets the first channel state
	a_shut_follow : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise
		|=> out_en_first_out == !$past(shut_sel[0])
	) else $error("First shutdown not committed");

	// Second shutdown bit sets the second channel state
	a_shut_second : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		sel_rise
		|=> out_en_second_out == !$past(shut_sel[1])
	) else $error("Second shutdown not committed");

	// Shutdown state moves only at a commit
	a_shut_hold : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		!$past(sel_rise)
		|-> $stable(out_en_first_out) && $stable(out_en_second_out)
	) else $error("Shutdown changed without commit");

	// Shut first channel shows zero
	a_shut_zero_first : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		!out_en_first_out
		|-> analog_out_first_out == `DDSC_CODE_OFF
	) else $error("Shut first channel still driven");

	// Shut second channel shows zero
	a_shut_zero : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		!out_en_second_out
		|-> analog_out_second_out == `DDSC_CODE_OFF
	) else $error("Shut second channel still driven");

	// Active first channel shows its code
	a_live_first : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		out_en_first_out
		|-> analog_out_first_out == code_first_out
	) else $error("First output differs from code");

	// Active second channel shows its code
	a_live_second : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		out_en_second_out
		|-> analog_out_second_out == code_second_out
	) else $error("Second output differs from code");

	// Waking first channel returns to the kept code
	a_wake_first : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(out_en_first_out)
		|-> analog_out_first_out == code_first_out
	) else $error("First channel wakes to wrong code");

	// Waking second channel returns to the kept code
	a_wake_second : assert property (
		@(posedge clk_in) disable iff (sys_rst_in)
		$rose(out_en_second_out)
		|-> analog_out_second_out == code_second_out
	) else $error("Second channel wakes to wrong code");
endmodule : ddsc_top
`default_nettype wire

// >>> tb_dual_dac_serial_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_dual_dac_serial_control;
	logic clk_in = 0, rst = 1, sc, sn, sd, cm, en1, en2, on, s1 = 0, s2 = 0;
	logic [7:0] ao1, ao2, c1, c2, e1 = 0, e2 = 0;
	logic [23:0] w;
	logic [15:0] cc [3] = '{16'h2380, 16'h38FF, 16'h2000};
	int seed = 61356, err_total = 0, n_tests = 0, k;
	always #12.5 clk_in = ~clk_in;
	ddsc_host host_u (.sclk_out(sc), .sel_n_out(sn), .sdo_out(sd));
	ddsc_top dut_u (.clk_in(clk_in), .sys_rst_in(rst), .ser_clk_in(sc),
		.sel_n_in(sn), .ser_data_in(sd), .commit_out(cm),
		.analog_out_first_out(ao1), .analog_out_second_out(ao2),
		.out_en_first_out(en1), .out_en_second_out(en2),
		.code_first_out(c1), .code_second_out(c2));
	// Expected channel output: zero while shut
	function automatic logic [7:0] vo(input logic s, input logic [7:0] c);
		return s ? 8'h00 : c;
	endfunction : vo
	// Compare and count
	task automatic chk(input string nm, input logic [7:0] ex, got);
		n_tests++;
		if (ex !== got) begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, ex, got);
		end
	endtask : chk
	// Verdict and end of run
	task automatic test_done;
		if (err_total == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : test_done
	// Corner words first, then random words
	initial begin
		repeat (3) @(negedge clk_in);
		rst = 0;
		repeat (4) @(negedge clk_in);
		for (int i = 0; i < 40; i++) begin
			if (i == 21) begin
				rst = 1; // Second reset mid-run
				repeat (3) @(negedge clk_in);
				chk("rst_code1", 8'h00, c1);
				chk("rst_code2", 8'h00, c2);
				chk("rst_en", 8'h03, {6'h00, en2, en1});
				chk("rst_out", 8'h00, ao1 | ao2);
				chk("rst_commit", 8'h00, 8'(cm));
				rst = 0;
				{e1, e2, s1, s2} = 18'h00000;
				repeat (4) @(negedge clk_in);
			end
			w = 24'($random(seed));
			w[13] = 1'b1;
			w[10] = 1'b0;
			if (i < 3) w = {8'h00, cc[i]};
			on = (i % 7 != 6);
			host_u.send(w, (i % 5 == 4) ? 20 : 16, (i % 3 == 0) ? 300 : 0, on);
			if (on && w[8]) e1 = w[7:0];
			if (on && w[9]) e2 = w[7:0];
			if (on) {s2, s1} = w[12:11];
			k = 0;
			while (cm !== 1'b1 && k < 40) begin
				@(negedge clk_in);
				k++;
			end
			chk("commit", 8'(on), 8'(k < 40));
			if (on && k == 40) test_done();
			chk("code1", e1, c1);
			chk("code2", e2, c2);
			chk("en1", 8'(!s1), 8'(en1));
			chk("en2", 8'(!s2), 8'(en2));
			chk("out1", vo(s1, e1), ao1);
			chk("out2", vo(s2, e2), ao2);
			repeat (10) @(negedge clk_in);
		end
		test_done();
	end
endmodule : tb_dual_dac_serial_control
`default_nettype wire
